// ===== design/evs_consts.vh
// Purpose: constants of the bus event sequencer and trigger block
// Assumes: AXI4-Lite register window, 32-bit words, byte addresses
// Notes: included by evs_event_sequencer.v and by the bench
//
// Notes on behaviour
// - satisfied event breaks, starts or stops timer
// - break waits programmed 16-bit bus-cycle delay
// - one delay counter, one delayed break event
// - action fires after pass count occurrences
// - evaluation starts at run, all unsatisfied
// - satisfied state latches until stop or reset
// - satisfied event never repeats its action
// - program stop clears every event
// - armed events need one arm source ready
// - reset event clears targets and pass counts
// - reset acts only on own satisfaction
// - staying satisfied issues no further resets
// - any one reset source resets target
// - sequencing only when enabled on detector
// - four trigger channels compare bus address
// - disabled trigger channel never drives output
// - enabled trigger address access drives pin high while running
// - disabled event keeps setup, does nothing
// - clear-all leaves every trigger channel disabled
// - trace events take no break or timer action
// - range channels lack timer, counts, sequencing
// - channel eight drives probe low one bus cycle
`ifndef EVS_CONSTS_VH
`define EVS_CONSTS_VH

// ************************************************************
// register byte offsets
// ************************************************************
`define EVS_OFS_CTRL      12'h000
`define EVS_OFS_STATUS    12'h004
`define EVS_OFS_DELAY     12'h008
`define EVS_OFS_TRIG_EN   12'h00c
`define EVS_OFS_TRIG_BASE 4'h1
`define EVS_OFS_CH_BASE   4'h1

// ************************************************************
// field positions
// ************************************************************
`define EVS_CTRL_RUN      0
`define EVS_CTRL_CLRALL   1
`define EVS_CFG_EN        0
`define EVS_CFG_ACT_LO    1
`define EVS_CFG_TRACE     3
`define EVS_CFG_SEQ       4
`define EVS_CFG_NOOCC     5
`define EVS_CFG_PASS_LO   16
`define EVS_SEQ_RST_LO    16
`define EVS_ST_TIMER      16
`define EVS_ST_DLY        17
`define EVS_DLY_CH_LO     16

// ************************************************************
// encodings and reset values
// ************************************************************
`define EVS_ACT_BREAK     2'h0
`define EVS_ACT_START     2'h1
`define EVS_ACT_STOP      2'h2
`define EVS_RESP_OKAY     2'h0
`define EVS_RESP_SLVERR   2'h2
`define EVS_RST_WORD      32'h00000000

`endif

// ===== design/evs_event_sequencer.v
// Purpose: bus event sequencer with break delay, pass counts and trigger outputs
// Assumes: aclk 100 MHz, synchronous active-low reset, target bus pins are asynchronous
// Notes: address, data and area comparators sit outside; their results arrive on ev_match
//
// Chosen here: the register offsets and register access over AXI4-Lite.

`include "evs_consts.vh"

module evs_event_sequencer #(
	parameter NCH  = 12,
	parameter NORD = 8,
	parameter AW   = 24,
	parameter NTRG = 4
) (
	input  wire          aclk,
	input  wire          aresetn,
	input  wire [11:0]   s_axi_awaddr,
	input  wire          s_axi_awvalid,
	output wire          s_axi_awready,
	input  wire [31:0]   s_axi_wdata,
	input  wire [3:0]    s_axi_wstrb,
	input  wire          s_axi_wvalid,
	output wire          s_axi_wready,
	output reg  [1:0]    s_axi_bresp,
	output reg           s_axi_bvalid,
	input  wire          s_axi_bready,
	input  wire [11:0]   s_axi_araddr,
	input  wire          s_axi_arvalid,
	output wire          s_axi_arready,
	output reg  [31:0]   s_axi_rdata,
	output reg  [1:0]    s_axi_rresp,
	output reg           s_axi_rvalid,
	input  wire          s_axi_rready,
	input  wire          bus_access,
	input  wire [AW-1:0] bus_addr,
	input  wire [NCH-1:0] ev_match,
	output reg           halt_request,
	output reg           run_active,
	output reg           run_timer_active,
	output reg  [NTRG-1:0] trigger_probe_connector,
	output reg           event_probe_connector_n
);

	// ************************************************************
	// pin synchronisers
	// ************************************************************
	reg  [AW+NCH:0]  sync1_r;
	reg  [AW+NCH:0]  sync2_r;
	reg              acc_d_r;
	wire             acc_s;
	wire [AW-1:0]    addr_s;
	wire [NCH-1:0]   match_s;
	wire             bus_strobe;

	// two flops per pin; only the second stage is looked at
	always @(posedge aclk) begin
		if (!aresetn) begin
			sync1_r <= {(AW+NCH+1){1'b0}};
			sync2_r <= {(AW+NCH+1){1'b0}};
			acc_d_r <= 1'b0;
		end else begin
			sync1_r <= {bus_access, bus_addr, ev_match};
			sync2_r <= sync1_r;
			acc_d_r <= sync2_r[AW+NCH];
		end
	end

	assign acc_s      = sync2_r[AW+NCH];
	assign addr_s     = sync2_r[AW+NCH-1:NCH];
	assign match_s    = sync2_r[NCH-1:0];
	// one pulse at the start of each bus cycle
	assign bus_strobe = acc_s & ~acc_d_r;

	// ************************************************************
	// register storage
	// ************************************************************
	reg  [31:0]      cfg_r [0:NCH-1];
	reg  [31:0]      seq_r [0:NCH-1];
	reg  [AW-1:0]    taddr_r [0:NTRG-1];
	reg  [NTRG-1:0]  ten_r;
	reg  [15:0]      dly_val_r;
	reg  [3:0]       dly_ch_r;
	wire [NCH-1:0]   sat_r;
	reg  [NCH-1:0]   rise_r;
	reg              dly_busy_r;
	reg  [15:0]      dly_cnt_r;

	// ************************************************************
	// axi4-lite slave
	// ************************************************************
	reg              aw_have_r;
	reg              w_have_r;
	reg  [11:0]      waddr_r;
	reg  [31:0]      wdata_r;
	reg  [3:0]       wstrb_r;
	wire             wr_go;
	reg  [31:0]      rd_val;
	reg              rd_err;
	reg              wr_err;

	assign s_axi_awready = ~aw_have_r;
	assign s_axi_wready  = ~w_have_r;
	assign s_axi_arready = ~s_axi_rvalid;
	assign wr_go         = aw_have_r & w_have_r & ~s_axi_bvalid;

	// byte-lane merge of a write into a stored word
	function [31:0] merge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0]  strb;
		integer b;
		begin
			merge = old;
			for (b = 0; b < 4; b = b + 1) begin
				if (strb[b])
					merge[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
	endfunction

	// address and data phases caught in either order
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_r    <= 1'b0;
			w_have_r     <= 1'b0;
			waddr_r      <= 12'h000;
			wdata_r      <= 32'h00000000;
			wstrb_r      <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `EVS_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && !aw_have_r) begin
				aw_have_r <= 1'b1;
				waddr_r   <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_have_r) begin
				w_have_r <= 1'b1;
				wdata_r  <= s_axi_wdata;
				wstrb_r  <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_have_r    <= 1'b0;
				w_have_r     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_err ? `EVS_RESP_SLVERR : `EVS_RESP_OKAY;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// read decode; unmapped words read zero with slverr
	always @* begin
		rd_val = 32'h00000000;
		rd_err = 1'b0;
		if (s_axi_araddr[11:8] == `EVS_OFS_CH_BASE && s_axi_araddr[7] == 1'b0 &&
				s_axi_araddr[6:3] < NCH) begin
			rd_val = s_axi_araddr[2] ? seq_r[s_axi_araddr[6:3]] : cfg_r[s_axi_araddr[6:3]];
		end else if (s_axi_araddr[11:4] == {4'h0, `EVS_OFS_TRIG_BASE}) begin
			rd_val[AW-1:0] = taddr_r[s_axi_araddr[3:2]];
		end else begin
			case (s_axi_araddr)
				`EVS_OFS_CTRL:    rd_val[`EVS_CTRL_RUN] = run_active;
				`EVS_OFS_STATUS:  rd_val = {14'h0000, dly_busy_r, run_timer_active,
							4'h0, sat_r};
				`EVS_OFS_DELAY:   rd_val = {12'h000, dly_ch_r, dly_val_r};
				`EVS_OFS_TRIG_EN: rd_val[NTRG-1:0] = ten_r;
				default:          rd_err = 1'b1;
			endcase
		end
	end

	// write decode check only; storage is below
	always @* begin
		wr_err = 1'b1;
		if (waddr_r[11:8] == `EVS_OFS_CH_BASE && waddr_r[7] == 1'b0 && waddr_r[6:3] < NCH)
			wr_err = 1'b0;
		else if (waddr_r[11:4] == {4'h0, `EVS_OFS_TRIG_BASE})
			wr_err = 1'b0;
		else if (waddr_r == `EVS_OFS_CTRL || waddr_r == `EVS_OFS_STATUS ||
				waddr_r == `EVS_OFS_DELAY || waddr_r == `EVS_OFS_TRIG_EN)
			wr_err = 1'b0;
	end

	// read answer one cycle after the address is taken
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= `EVS_RESP_OKAY;
		end else if (s_axi_arvalid && !s_axi_rvalid) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_val;
			s_axi_rresp  <= rd_err ? `EVS_RESP_SLVERR : `EVS_RESP_OKAY;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ************************************************************
	// configuration writes
	// ************************************************************
	wire wr_ctrl  = wr_go && waddr_r == `EVS_OFS_CTRL;
	wire clr_all  = wr_ctrl && wstrb_r[0] && wdata_r[`EVS_CTRL_CLRALL];
	wire [31:0] taddr_mrg = merge({{(32-AW){1'b0}}, taddr_r[waddr_r[3:2]]}, wdata_r, wstrb_r);
	integer k;

	// event setup, trigger setup and delay setup
	always @(posedge aclk) begin
		if (!aresetn) begin
			for (k = 0; k < NCH; k = k + 1) begin
				cfg_r[k] <= `EVS_RST_WORD;
				seq_r[k] <= `EVS_RST_WORD;
			end
			for (k = 0; k < NTRG; k = k + 1)
				taddr_r[k] <= {AW{1'b0}};
			ten_r     <= {NTRG{1'b0}};
			dly_val_r <= 16'h0000;
			dly_ch_r  <= 4'h0;
		end else begin
			if (wr_go && !wr_err && waddr_r[11:8] == `EVS_OFS_CH_BASE) begin
				if (waddr_r[2])
					seq_r[waddr_r[6:3]] <= merge(seq_r[waddr_r[6:3]], wdata_r, wstrb_r);
				else
					cfg_r[waddr_r[6:3]] <= merge(cfg_r[waddr_r[6:3]], wdata_r, wstrb_r);
			end
			if (wr_go && waddr_r[11:4] == {4'h0, `EVS_OFS_TRIG_BASE})
				taddr_r[waddr_r[3:2]] <= taddr_mrg[AW-1:0];
			if (wr_go && waddr_r == `EVS_OFS_DELAY) begin
				if (wstrb_r[0])
					dly_val_r[7:0] <= wdata_r[7:0];
				if (wstrb_r[1])
					dly_val_r[15:8] <= wdata_r[15:8];
				if (wstrb_r[2])
					dly_ch_r <= wdata_r[`EVS_DLY_CH_LO +: 4];
			end
			if (wr_go && waddr_r == `EVS_OFS_TRIG_EN && wstrb_r[0])
				ten_r <= wdata_r[NTRG-1:0];
			if (clr_all) begin
				ten_r <= {NTRG{1'b0}};
				for (k = 0; k < NCH; k = k + 1)
					cfg_r[k][`EVS_CFG_EN] <= 1'b0;
			end
		end
	end

	// ************************************************************
	// event channels
	// ************************************************************
	wire [NCH-1:0] fire;
	wire [NCH-1:0] brk_now;
	wire [NCH-1:0] brk_dly;
	wire [NCH-1:0] tstart;
	wire [NCH-1:0] tstop;
	wire           dly_done;
	wire           do_break;

	genvar i;
	generate
		for (i = 0; i < NCH; i = i + 1) begin : g_ch
			reg  [15:0] cnt_r;
			reg         hold_r;
			wire [31:0] c      = cfg_r[i];
			wire [NCH-1:0] arm = seq_r[i][NCH-1:0];
			wire [NCH-1:0] rst = seq_r[i][`EVS_SEQ_RST_LO +: NCH];
			wire [1:0]  act    = c[`EVS_CFG_ACT_LO +: 2];
			wire        ord    = (i < NORD);
			wire        seq_on = c[`EVS_CFG_SEQ] & ord;
			// range channels cap pass count at one
			wire [15:0] pass   = ord ? c[`EVS_CFG_PASS_LO +: 16] :
						{15'h0000, |c[`EVS_CFG_PASS_LO +: 16]};
			// any one arm source in required state
			wire        armed  = !seq_on || arm == {NCH{1'b0}} ||
						(c[`EVS_CFG_NOOCC] ? |(arm & ~sat_r) : |(arm & sat_r));
			wire        rhit   = seq_on && |(rst & rise_r);
			wire        occ    = bus_strobe & match_s[i] & c[`EVS_CFG_EN] & armed &
						run_active & ~sat_r[i] & ~rhit;
			wire        reach  = ({1'b0, cnt_r} + 17'h00001) >= {1'b0, pass};
			wire        acts   = fire[i] & ~c[`EVS_CFG_TRACE];
			wire        owner  = (dly_ch_r == i) && (dly_val_r != 16'h0000);

			assign fire[i]    = occ & reach;
			assign brk_now[i] = acts && act == `EVS_ACT_BREAK && !owner;
			assign brk_dly[i] = acts && act == `EVS_ACT_BREAK && owner;
			assign tstart[i]  = acts && act == `EVS_ACT_START && ord;
			assign tstop[i]   = acts && act == `EVS_ACT_STOP && ord;

			assign sat_r[i]   = hold_r;
			// satisfied latch and pass counter
			always @(posedge aclk) begin
				if (!aresetn) begin
					hold_r   <= 1'b0;
					cnt_r    <= 16'h0000;
				end else if (!run_active) begin
					hold_r   <= 1'b0;
					cnt_r    <= 16'h0000;
				end else if (rhit) begin
					hold_r   <= 1'b0;
					cnt_r    <= 16'h0000;
				end else if (fire[i]) begin
					hold_r   <= 1'b1;
				end else if (occ) begin
					cnt_r <= cnt_r + 16'h0001;
				end
			end
		end
	endgenerate

	// newly satisfied events, seen by reset targets next cycle
	always @(posedge aclk) begin
		if (!aresetn)
			rise_r <= {NCH{1'b0}};
		else
			rise_r <= fire;
	end

	// ************************************************************
	// break delay, break and run timer
	// ************************************************************
	assign dly_done = dly_busy_r & bus_strobe & (dly_cnt_r == 16'h0001);
	assign do_break = |brk_now | dly_done;

	// load, count bus cycles, break at zero
	always @(posedge aclk) begin
		if (!aresetn || !run_active) begin
			dly_busy_r <= 1'b0;
			dly_cnt_r  <= 16'h0000;
		end else if (|brk_dly) begin
			dly_busy_r <= 1'b1;
			dly_cnt_r  <= dly_val_r;
		end else if (dly_busy_r && bus_strobe) begin
			dly_cnt_r  <= dly_cnt_r - 16'h0001;
			if (dly_cnt_r == 16'h0001)
				dly_busy_r <= 1'b0;
		end
	end

	// run control: software starts and stops, a break halts
	always @(posedge aclk) begin
		if (!aresetn) begin
			run_active   <= 1'b0;
			halt_request <= 1'b0;
		end else begin
			halt_request <= do_break;
			if (do_break)
				run_active <= 1'b0;
			else if (wr_ctrl && wstrb_r[0])
				run_active <= wdata_r[`EVS_CTRL_RUN];
		end
	end

	always @(posedge aclk) begin
		if (!aresetn || !run_active)
			run_timer_active <= 1'b0;
		else if (|tstop)
			run_timer_active <= 1'b0;
		else if (|tstart)
			run_timer_active <= 1'b1;
	end

	// ************************************************************
	// probe outputs
	// ************************************************************
	// channel eight low for one bus cycle
	always @(posedge aclk) begin
		if (!aresetn)
			event_probe_connector_n <= 1'b1;
		else if (fire[7])
			event_probe_connector_n <= 1'b0;
		else if (bus_strobe || !acc_s)
			event_probe_connector_n <= 1'b1;
	end

	wire [NTRG-1:0] trg_nxt;
	generate
		for (i = 0; i < NTRG; i = i + 1) begin : g_trg
			assign trg_nxt[i] = ten_r[i] & acc_s & run_active & (addr_s == taddr_r[i]);
		end
	endgenerate

	// all trigger outputs registered in one process
	always @(posedge aclk) begin
		if (!aresetn)
			trigger_probe_connector <= {NTRG{1'b0}};
		else
			trigger_probe_connector <= trg_nxt;
	end

endmodule

// ===== tb/evs_target_bus.sv
// Purpose: target processor bus model issuing whole bus cycles
// Assumes: one cycle per start pulse, start only while idle
// Notes: address lines show the inverse of the last address outside a cycle
module evs_target_bus #(
	parameter int AW  = 24,
	parameter int NCH = 12
) (
	input  wire logic           aclk,
	input  wire logic           start,
	input  wire logic [AW-1:0]  addr_in,
	input  wire logic [NCH-1:0] match_in,
	output logic                bus_access,
	output logic [AW-1:0]       bus_addr,
	output logic [NCH-1:0]      ev_match,
	output logic                done
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0]     cnt_r = 4'h0;
	logic [AW-1:0]  addr_r = '0;
	logic [NCH-1:0] match_r = '0;
	// four clocks of access, then eight idle clocks
	always @(posedge aclk) begin
		if (start && cnt_r == 4'h0) begin
			cnt_r <= 4'hc;
			addr_r <= addr_in;
			match_r <= match_in;
		end else if (cnt_r != 4'h0) begin
			cnt_r <= cnt_r - 4'h1;
		end
	end
	// released address lines never hold the last value; match lines go to zero
	assign bus_access = cnt_r > 4'h8;
	assign bus_addr = bus_access ? addr_r : ~addr_r;
	assign ev_match = bus_access ? match_r : '0;
	assign done = cnt_r == 4'h1;
endmodule

// ===== tb/evs_event_sequencer_properties.sv
// Purpose: port-level properties of the event sequencer
// Assumes: single clock domain, synchronous active-low reset
// Notes: bound to every instance of the design
module evs_event_sequencer_properties #(
	parameter NTRG = 4
) (
	input wire logic            aclk,
	input wire logic            aresetn,
	input wire logic            s_axi_bvalid,
	input wire logic            s_axi_bready,
	input wire logic            s_axi_arvalid,
	input wire logic            s_axi_arready,
	input wire logic [31:0]     s_axi_rdata,
	input wire logic            s_axi_rvalid,
	input wire logic            s_axi_rready,
	input wire logic            halt_request,
	input wire logic            run_active,
	input wire logic            run_timer_active,
	input wire logic [NTRG-1:0] trigger_probe_connector,
	input wire logic            event_probe_connector_n
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence rd_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence run_idle;
		(!run_active) [*2];
	endsequence
	a_halt_one_pulse: assert property (halt_request |=> !halt_request)
		else $error("halt request longer than one cycle");
	a_halt_stops_run: assert property (halt_request |-> !run_active)
		else $error("run still active at halt");
	a_halt_needs_run: assert property ($rose(halt_request) |-> $past(run_active))
		else $error("halt without running program");
	a_timer_needs_run: assert property (run_idle |-> !run_timer_active)
		else $error("run timer active while stopped");
	a_trig_idle_stop: assert property (run_idle |-> trigger_probe_connector == '0)
		else $error("trigger output while stopped");
	a_probe_pulse_short: assert property ($fell(event_probe_connector_n)
		|-> ##[1:16] event_probe_connector_n)
		else $error("event probe held low too long");
	a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped early");
	a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
	a_read_answer: assert property (rd_take |=> s_axi_rvalid)
		else $error("read answer late");
endmodule
bind evs_event_sequencer evs_event_sequencer_properties #(.NTRG(NTRG)) i_props (.aclk, .aresetn,
	.s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
	.s_axi_rready, .halt_request, .run_active, .run_timer_active, .trigger_probe_connector,
	.event_probe_connector_n);

// ===== tb/evs_event_sequencer_bench.sv
// Purpose: self-checking bench of the event sequencer
// Assumes: target bus model drives whole bus cycles
// Notes: AXI4-Lite master tasks sample handshakes at the falling edge
`include "evs_consts.vh"
module evs_event_sequencer_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, bus_access;
	logic halt_request, run_active, run_timer_active, event_probe_connector_n, go, done, pr_seen;
	logic [11:0] s_axi_awaddr, s_axi_araddr, ev_match, go_match;
	logic [31:0] s_axi_wdata, s_axi_rdata, rv;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
	logic [3:0]  s_axi_wstrb, trigger_probe_connector, tr_seen;
	logic [23:0] bus_addr, go_addr;
	int          err_total, n_tests, n_halt;
	evs_event_sequencer i_evs_event_sequencer (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .bus_access, .bus_addr, .ev_match,
		.halt_request, .run_active, .run_timer_active, .trigger_probe_connector,
		.event_probe_connector_n);
	evs_target_bus i_evs_target_bus (.aclk, .start(go), .addr_in(go_addr), .match_in(go_match),
		.bus_access, .bus_addr, .ev_match, .done);
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	// watch halts, triggers and the event probe
	always @(posedge aclk) begin
		if (halt_request === 1'b1) n_halt++;
		tr_seen = tr_seen | trigger_probe_connector;
		if (event_probe_connector_n === 1'b0) pr_seen = 1'b1;
	end
	task automatic complete_run;
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, got);
		n_tests++;
		if (got !== exp) begin
			$display("Error %s expected %h seen %h", nm, exp, got);
			err_total++;
		end
	endtask
	task automatic tmo;
		err_total++;
		complete_run;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		int i;
		logic ta, tw, tb;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (i = 0; i < 40; i++) begin
			@(negedge aclk);
			ta = s_axi_awvalid & s_axi_awready;
			tw = s_axi_wvalid & s_axi_wready;
			tb = s_axi_bvalid;
			rs = s_axi_bresp;
			@(posedge aclk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
			if (tb) break;
		end
		s_axi_bready <= 1'b0;
		if (i == 40) tmo;
	endtask
	task automatic rd(input logic [11:0] a);
		int i;
		logic ta, tr;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (i = 0; i < 40; i++) begin
			@(negedge aclk);
			ta = s_axi_arvalid & s_axi_arready;
			tr = s_axi_rvalid;
			rv = s_axi_rdata;
			rs = s_axi_rresp;
			@(posedge aclk);
			if (ta) s_axi_arvalid <= 1'b0;
			if (tr) break;
		end
		s_axi_rready <= 1'b0;
		if (i == 40) tmo;
	endtask
	task automatic rc(input logic [11:0] a, input logic [31:0] exp, input string nm);
		rd(a);
		chk(nm, exp, rv);
	endtask
	// one whole bus cycle from the target model
	task automatic cyc(input logic [23:0] a, input logic [11:0] m);
		int i;
		@(posedge aclk);
		go_addr <= a;
		go_match <= m;
		go <= 1'b1;
		@(posedge aclk);
		go <= 1'b0;
		for (i = 0; i < 40; i++) begin
			@(negedge aclk);
			if (done === 1'b1) break;
		end
		if (i == 40) tmo;
	endtask
	task automatic clr;
		@(negedge aclk);
		n_halt = 0;
		tr_seen = 4'h0;
		pr_seen = 1'b0;
	endtask
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, go} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, go_addr, go_match} = '0;
		s_axi_wstrb = 4'hf;
		{err_total, n_tests, n_halt} = '0;
		{tr_seen, pr_seen} = '0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		rc(`EVS_OFS_STATUS, 32'h0, "status");
		rd(12'h0f0);
		chk("unmapped", `EVS_RESP_SLVERR, rs);
		wr(12'h0f0, 32'h1);
		chk("bresp unmapped", `EVS_RESP_SLVERR, rs);
		s_axi_wstrb <= 4'h3;
		wr(`EVS_OFS_DELAY, 32'hffffffff);
		s_axi_wstrb <= 4'hf;
		chk("bresp okay", `EVS_RESP_OKAY, rs);
		rc(`EVS_OFS_DELAY, 32'h0000ffff, "byte strobes");
		wr(`EVS_OFS_DELAY, 32'h0);
		$display("reset test done");
		wr(12'h100, 32'h00020001);
		wr(`EVS_OFS_CTRL, 32'h1);
		clr;
		cyc(24'h0, 12'h001);
		chk("halt first", 32'h0, n_halt);
		cyc(24'h0, 12'h001);
		chk("halt second", 32'h1, n_halt);
		rc(`EVS_OFS_CTRL, 32'h0, "run");
		rc(`EVS_OFS_STATUS, 32'h0, "sat");
		$display("pass count test done");
		wr(12'h100, 32'h0);
		wr(12'h108, 32'h3);
		wr(12'h110, 32'h5);
		wr(`EVS_OFS_CTRL, 32'h1);
		cyc(24'h0, 12'h002);
		rc(`EVS_OFS_STATUS, 32'h00010002, "timer on");
		cyc(24'h0, 12'h004);
		chk("timer off", 32'h0, run_timer_active);
		cyc(24'h0, 12'h002);
		chk("no repeat", 32'h0, run_timer_active);
		wr(`EVS_OFS_CTRL, 32'h0);
		$display("timer test done");
		wr(12'h108, 32'h0);
		wr(12'h110, 32'h0);
		wr(12'h100, 32'h1);
		wr(`EVS_OFS_DELAY, 32'h3);
		wr(`EVS_OFS_CTRL, 32'h1);
		clr;
		cyc(24'h0, 12'h001);
		rc(`EVS_OFS_STATUS, 32'h00020001, "delay busy");
		cyc(24'h0, 12'h0);
		cyc(24'h0, 12'h0);
		chk("halt early", 32'h0, n_halt);
		cyc(24'h0, 12'h0);
		chk("halt delayed", 32'h1, n_halt);
		wr(`EVS_OFS_DELAY, 32'h0);
		wr(12'h100, 32'h0);
		$display("delay test done");
		wr(12'h118, 32'h13);
		wr(12'h11c, 32'h00200010);
		wr(12'h120, 32'h13);
		wr(12'h128, 32'h13);
		wr(12'h130, 32'h12);
		wr(`EVS_OFS_CTRL, 32'h1);
		cyc(24'h0, 12'h008);
		rc(`EVS_OFS_STATUS, 32'h0, "unarmed");
		cyc(24'h0, 12'h010);
		cyc(24'h0, 12'h048);
		rc(`EVS_OFS_STATUS, 32'h00010018, "armed");
		cyc(24'h0, 12'h020);
		rc(`EVS_OFS_STATUS, 32'h00010030, "reset");
		wr(`EVS_OFS_CTRL, 32'h0);
		rc(`EVS_OFS_STATUS, 32'h0, "stop");
		$display("sequence test done");
		wr(12'h010, 32'h1234);
		wr(`EVS_OFS_TRIG_EN, 32'h1);
		wr(12'h138, 32'h3);
		wr(`EVS_OFS_CTRL, 32'h1);
		clr;
		cyc(24'h1234, 12'h080);
		chk("trigger", 32'h1, tr_seen);
		chk("probe", 32'h1, pr_seen);
		clr;
		cyc(24'h1235, 12'h0);
		chk("other address", 32'h0, tr_seen);
		wr(`EVS_OFS_CTRL, 32'h3);
		rc(`EVS_OFS_TRIG_EN, 32'h0, "clear all");
		clr;
		cyc(24'h1234, 12'h0);
		chk("disabled", 32'h0, tr_seen);
		$display("trigger test done");
		wr(`EVS_OFS_CTRL, 32'h0);
		wr(12'h108, 32'h33);
		wr(12'h10c, 32'h00600004);
		wr(12'h110, 32'h15);
		wr(12'h114, 32'h00040000);
		wr(12'h120, 32'h3);
		wr(12'h124, 32'h800);
		wr(12'h130, 32'h3);
		wr(`EVS_OFS_CTRL, 32'h1);
		cyc(24'h0, 12'h004);
		rc(`EVS_OFS_STATUS, 32'h0, "self reset");
		cyc(24'h0, 12'h012);
		rc(`EVS_OFS_STATUS, 32'h00010012, "no occurrence arm");
		cyc(24'h0, 12'h040);
		rc(`EVS_OFS_STATUS, 32'h00010050, "any reset source");
		cyc(24'h0, 12'h042);
		rc(`EVS_OFS_STATUS, 32'h00010052, "no second reset");
		wr(`EVS_OFS_CTRL, 32'h0);
		$display("arm and reset test done");
		wr(12'h100, 32'h9);
		wr(12'h140, 32'h00050001);
		wr(12'h148, 32'h3);
		wr(`EVS_OFS_CTRL, 32'h1);
		clr;
		cyc(24'h0, 12'h201);
		rc(`EVS_OFS_STATUS, 32'h00000201, "trace and range");
		chk("trace no halt", 32'h0, n_halt);
		cyc(24'h0, 12'h100);
		chk("range pass cap", 32'h1, n_halt);
		$display("range test done");
		wr(`EVS_OFS_CTRL, 32'h1);
		cyc(24'h0, 12'h010);
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rc(`EVS_OFS_STATUS, 32'h0, "status after reset");
		rc(12'h140, 32'h0, "setup after reset");
		$display("mid-run reset test done");
		complete_run;
	end
endmodule
